// [window_alarm_consts.vh]
// Purpose: constants for the window alarm controller
// Assumes: system clock of 10 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef WINDOW_ALARM_CONSTS_VH
`define WINDOW_ALARM_CONSTS_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      100

// ----------------------------------------------------------------------
// timing, least times rounded up to whole cycles
// ----------------------------------------------------------------------
`define HOLD_CLEAR_NS      4000
`define HOLD_CLEAR_CYC     ((`HOLD_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_RISE_NS       10000
`define MODE_RISE_CYC      ((`MODE_RISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_FALL_NS       100000
`define MODE_FALL_CYC      ((`MODE_FALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define CNT_W              10
`define SYNC_RST_VAL       1'b1
`define HOLD_CTL_RST_VAL   1'b0
`define POS_ONLY_RST_VAL   1'b0

`endif

// [pin_sync.v]
// Purpose: two-stage synchroniser for pin inputs
// Assumes: one clock, clock enable freezes state
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
`include "window_alarm_consts.vh"

module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  input  wire             clk_en_in,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------------
  // per bit two flip-flops
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_r   <= `SYNC_RST_VAL;
          stable_r <= `SYNC_RST_VAL;
        end else if (clk_en_in) begin
          meta_r   <= pin_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate

endmodule

// [window_alarm_ctrl.v]
// Purpose: controller driving the hold pin and mode select of an
//          isolated window comparator and watching its alarm pin
// Assumes: alarm pin is open drain with pull-up, low means alarm
// Notes:   all outputs registered
//
// How it works
// - controller never moves mode select while alarm handling is active.
// - controller clears a held alarm with hold pin low at least 4 us.
// - controller raises hold pin again afterwards to re-arm hold mode.
// - controller reacts to the alarm pin high-to-low change as an event, except in ST_SETTLE.
`timescale 1ns/10ps
`include "window_alarm_consts.vh"

module window_alarm_ctrl (
  input  wire sys_clk_in,
  input  wire rst_b_in,
  input  wire clk_en_in,
  input  wire alarm_n_in,
  input  wire hold_mode_in,
  input  wire clear_req_in,
  input  wire pos_only_req_in,
  output reg  hold_ctl_out,
  output reg  pos_only_out,
  output reg  alarm_event_out,
  output reg  alarm_active_out,
  output reg  alarm_held_out,
  output reg  clear_busy_out,
  output reg  settle_busy_out
);

  // --------------------------------------------------------------------
  // states and counts
  // --------------------------------------------------------------------
  localparam [1:0] ST_TRANSP = 2'b00;
  localparam [1:0] ST_ARMED  = 2'b01;
  localparam [1:0] ST_CLEAR  = 2'b10;
  localparam [1:0] ST_SETTLE = 2'b11;

  localparam integer      CLEAR_INT = `HOLD_CLEAR_CYC;
  localparam integer      RISE_INT  = `MODE_RISE_CYC;
  localparam integer      FALL_INT  = `MODE_FALL_CYC;

  // counts fit the counter width, cut on purpose
  localparam [`CNT_W-1:0] CLEAR_CYC = CLEAR_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RISE_CYC  = RISE_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] FALL_CYC  = FALL_INT[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CNT_ONE   = 10'h001;

  reg [1:0]        state_r;
  reg [1:0]        state_nxt;
  reg [`CNT_W-1:0] cnt_r;
  reg [`CNT_W-1:0] cnt_nxt;
  reg              hold_nxt;
  reg              pos_only_nxt;
  reg              prev_alarm_r;
  reg              held_nxt;

  wire             alarm_n_sync;
  wire             alarm_now;
  wire             alarm_fall;

  // --------------------------------------------------------------------
  // alarm pin synchroniser
  // --------------------------------------------------------------------
  pin_sync #(
    .WIDTH (1)
  ) u_alarm_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .clk_en_in  (clk_en_in),
    .pin_in     (alarm_n_in),
    .sync_out   (alarm_n_sync)
  );

  // low pin means out of range
  assign alarm_now  = ~alarm_n_sync;
  // high-to-low change of the pin
  assign alarm_fall = alarm_now & ~prev_alarm_r;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always @* begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    hold_nxt     = hold_ctl_out;
    pos_only_nxt = pos_only_out;
    held_nxt     = alarm_held_out;
    case (state_r)
      ST_TRANSP: begin
        hold_nxt = 1'b0;
        held_nxt = 1'b0;
        if (pos_only_req_in != pos_only_out) begin
          pos_only_nxt = pos_only_req_in;
          cnt_nxt      = pos_only_req_in ? RISE_CYC : FALL_CYC;
          state_nxt    = ST_SETTLE;
        end else if (hold_mode_in) begin
          hold_nxt  = 1'b1;
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (alarm_now) begin
          held_nxt = 1'b1;
        end
        if (clear_req_in || !hold_mode_in) begin
          hold_nxt  = 1'b0;
          cnt_nxt   = CLEAR_CYC;
          state_nxt = ST_CLEAR;
        end else if (pos_only_req_in != pos_only_out) begin
          hold_nxt  = 1'b0;
          state_nxt = ST_TRANSP;
        end
      end
      ST_CLEAR: begin
        hold_nxt = 1'b0;
        if (cnt_r > CNT_ONE) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end else begin
          // alarm still low here means input still beyond threshold
          held_nxt = alarm_now;
          if (hold_mode_in && (pos_only_req_in == pos_only_out)) begin
            hold_nxt  = 1'b1;
            state_nxt = ST_ARMED;
          end else begin
            state_nxt = ST_TRANSP;
          end
        end
      end
      ST_SETTLE: begin
        hold_nxt = 1'b0;
        held_nxt = 1'b0;
        if (cnt_r > CNT_ONE) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end else begin
          state_nxt = ST_TRANSP;
        end
      end
      default: begin
        state_nxt = ST_TRANSP;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // state and counter registers
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_TRANSP;
      cnt_r   <= {`CNT_W{1'b0}};
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // --------------------------------------------------------------------
  // device pin drives
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_ctl_out <= `HOLD_CTL_RST_VAL;
      pos_only_out <= `POS_ONLY_RST_VAL;
    end else if (clk_en_in) begin
      hold_ctl_out <= hold_nxt;
      pos_only_out <= pos_only_nxt;
    end
  end

  // --------------------------------------------------------------------
  // alarm path
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_alarm_r     <= 1'b0;
      alarm_event_out  <= 1'b0;
      alarm_active_out <= 1'b0;
    end else if (clk_en_in) begin
      prev_alarm_r     <= alarm_now;
      // events during a mode change may be spurious
      alarm_event_out  <= alarm_fall & (state_r != ST_SETTLE);
      alarm_active_out <= alarm_now;
    end
  end

  // --------------------------------------------------------------------
  // held flag
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alarm_held_out <= 1'b0;
    end else if (clk_en_in) begin
      alarm_held_out <= held_nxt;
    end
  end

  // --------------------------------------------------------------------
  // busy flags
  // --------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clear_busy_out  <= 1'b0;
      settle_busy_out <= 1'b0;
    end else if (clk_en_in) begin
      clear_busy_out  <= (state_nxt == ST_CLEAR);
      settle_busy_out <= (state_nxt == ST_SETTLE);
    end
  end

endmodule

// [alarm_dev_model.sv]
// Purpose: device model for the window alarm bench
// Assumes: trip inputs are the comparator states
// Notes:   open drain, pull-up made in the bench
`timescale 1ns/10ps
module alarm_dev_model (
  input  wire logic clk_in,
  input  wire logic hold_pin_in,
  input  wire logic pos_only_in,
  input  wire logic trip_pos_in,
  input  wire logic trip_neg_in,
  output wire logic pull_low_out
);
  logic       held_r = 1'b0;
  logic [5:0] low_r  = 6'h00;
  wire        oor = trip_pos_in | (trip_neg_in & ~pos_only_in);
  always @(posedge clk_in) begin
    low_r <= (hold_pin_in || low_r == 6'h1E) ? 6'h00 : low_r + 6'h01;
    if (oor && hold_pin_in) held_r <= 1'b1;
    else if (low_r == 6'h1E) held_r <= 1'b0;
  end
  assign pull_low_out = oor | held_r;
endmodule

// [window_alarm_monitor.sv]
// Purpose: port checker for window_alarm_ctrl
// Assumes: clock enable held high
// Notes:   bound after the module
`timescale 1ns/10ps
module window_alarm_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic alarm_n_in,
  input wire logic hold_ctl_out,
  input wire logic pos_only_out,
  input wire logic alarm_event_out,
  input wire logic alarm_active_out,
  input wire logic alarm_held_out,
  input wire logic clear_busy_out,
  input wire logic settle_busy_out
);
  logic [9:0] clr_r;
  logic [9:0] set_r;
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clr_r <= 10'h000;
      set_r <= 10'h000;
    end else begin
      clr_r <= clear_busy_out ? clr_r + 10'h001 : 10'h000;
      set_r <= settle_busy_out ? set_r + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  clear_low_a: assert property (clear_busy_out |-> !hold_ctl_out)
    else $error("hold pin high in clear");
  clear_len_a: assert property ($fell(clear_busy_out) |-> clr_r == 10'h028)
    else $error("clear length wrong");
  mode_move_a: assert property ($changed(pos_only_out) |-> settle_busy_out)
    else $error("mode moved outside settle");
  settle_low_a: assert property (settle_busy_out |-> !hold_ctl_out)
    else $error("hold pin high in settle");
  settle_len_a: assert property ($fell(settle_busy_out) |->
    set_r == (pos_only_out ? 10'h064 : 10'h3E8)) else $error("settle wrong");
  event_edge_a: assert property (alarm_event_out |->
    alarm_active_out && !$past(alarm_active_out)) else $error("bad event");
  alarm_seen_a: assert property ($fell(alarm_n_in) |-> ##[1:3] alarm_active_out)
    else $error("alarm missed");
  held_drop_a: assert property ($fell(alarm_held_out) |-> $past(clear_busy_out))
    else $error("held dropped without clear");
  cover property ($rose(clear_busy_out));
  cover property ($rose(settle_busy_out) && pos_only_out);
  cover property (alarm_event_out);
endmodule
bind window_alarm_ctrl window_alarm_monitor u_window_alarm_monitor (.*);

// [tb_top.sv]
// Purpose: self-checking bench for window_alarm_ctrl
// Assumes: device model with pull-up on the alarm pin
// Notes:   alarm events checked from a queue
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t wrong value", $time); end end
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, hold_m = 1'b0, clr_q = 1'b0, pos_q = 1'b0;
  logic tp = 1'b0, tn = 1'b0, r, clk_en = 1'b1;
  wire  hold_c, pos_o, ev, act, held, c_busy, s_busy, pull;
  wire  alarm_n = ~pull;
  int   mismatches = 0, checks_done = 0;
  bit   exp_q[$];
  window_alarm_ctrl u_window_alarm_ctrl (.sys_clk_in(clk), .rst_b_in(rst_b),
    .clk_en_in(clk_en), .alarm_n_in(alarm_n), .hold_mode_in(hold_m),
    .clear_req_in(clr_q), .pos_only_req_in(pos_q), .hold_ctl_out(hold_c),
    .pos_only_out(pos_o), .alarm_event_out(ev), .alarm_active_out(act),
    .alarm_held_out(held), .clear_busy_out(c_busy),
    .settle_busy_out(s_busy));
  alarm_dev_model u_alarm_dev_model (.clk_in(clk), .hold_pin_in(hold_c),
    .pos_only_in(pos_o), .trip_pos_in(tp), .trip_neg_in(tn),
    .pull_low_out(pull));
  initial forever #50 clk = ~clk;
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task give_verdict;
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) if (ev === 1'b1) begin
    if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
    else `CHK(act, exp_q.pop_front())
  end
  initial begin
    #1000000;
    mismatches++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h6FEC));
    step(20);
    rst_b = 1'b1;
    `CHK({hold_c, pos_o, held}, 3'h0)
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back(1'b1);
      {tp, tn} = i ? 2'b01 : 2'b10;
      step(6);
      `CHK({alarm_n, act}, 2'b01)
      {tp, tn} = 2'b00;
      step(6);
      `CHK({alarm_n, act, held}, 3'h4)
    end
    hold_m = 1'b1;
    step(3);
    `CHK(hold_c, 1'b1)
    for (int i = 0; i < 2; i++) begin
      exp_q.push_back(1'b1);
      tp = 1'b1;
      step(6);
      tp = i[0];
      step(6);
      `CHK({alarm_n, held}, 2'b01)
      clr_q = 1'b1;
      step(1);
      clr_q = 1'b0;
      step(1);
      `CHK({hold_c, c_busy}, 2'b01)
      step(45);
      `CHK({hold_c, alarm_n, held}, {2'b11 ^ {1'b0, i[0]}, i[0]})
    end
    tp = 1'b0;
    hold_m = 1'b0;
    step(50);
    `CHK({hold_c, alarm_n, held}, 3'h2)
    pos_q = 1'b1;
    tn = 1'b1;
    step(2);
    `CHK({pos_o, s_busy}, 2'b11)
    step(110);
    `CHK({s_busy, act}, 2'b00)
    tn = 1'b0;
    pos_q = 1'b0;
    step(500);
    `CHK({pos_o, s_busy}, 2'b01)
    step(510);
    `CHK(s_busy, 1'b0)
    for (int i = 0; i < 12; i++) begin
      r = 1'($urandom());
      if (r && !tp) exp_q.push_back(1'b1);
      tp = r;
      step(6);
      `CHK(act, r)
    end
    tp = 1'b0;
    clk_en = 1'b0;
    hold_m = 1'b1;
    step(4);
    `CHK(hold_c, 1'b0)
    clk_en = 1'b1;
    step(3);
    `CHK(hold_c, 1'b1)
    hold_m = 1'b0;
    step(50);
    `CHK({hold_c, c_busy}, 2'b00)
    step(6);
    `CHK(exp_q.size() == 0, 1'b1)
    give_verdict;
  end
endmodule
